// ---- ipgo_gpio.sv ----
// pin output-data block with apb register access for the two serial pins
// Operation
// - one output bit per pin, data and clock
// - output bits held, always readable
// - function/direction writes leave output bits
// - drive only in gpio mode and output direction
// - bits 31-2 read zero, writes ignored
// - bit 1 sets data pin level
// - bit 0 sets clock pin level
// - reads return stored bits, not pins
// - open-drain pin cannot be driven high
// - set alias ones set output bits
// - set alias reads are indeterminate
// - set alias bit 1 acts on data
// - set alias bit 0 acts on clock
// - function bit: 0 serial role, 1 gpio
// - direction bit: 0 input, 1 output
// - clear alias ones clear output bits
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module ipgo_gpio #(
    parameter bit DATA_OPEN_DRAIN = 1'b0,
    parameter bit CLOCK_OPEN_DRAIN = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe_o,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_o,
    output logic gpio_function_select_o
);
    typedef struct packed {
        logic [1:0] pin_output_data;
        logic [1:0] direction_bits;
        logic gpio_function_select;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } ipgo_state_t;

    ipgo_state_t state_q;
    ipgo_state_t state_d;
    ipgo_pkg::ipgo_acc_t acc;
    logic [1:0] pins_sync;
    logic [1:0] wbits;
    logic setup;

    // ************************************************************
    // pin input synchronisers
    // ************************************************************
    ipgo_sync #(
        .WIDTH(ipgo_pkg::NUM_PINS)
    ) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .async_i({serial_data_pin_i, serial_clock_pin_i}),
        .sync_o(pins_sync)
    );

    // ************************************************************
    // address decode
    // ************************************************************
    always_comb begin
        unique case (paddr_i)
            ipgo_pkg::PIN_FUNCTION_OFS: acc = ipgo_pkg::IPGO_ACC_FUNC;
            ipgo_pkg::PIN_DIRECTION_OFS: acc = ipgo_pkg::IPGO_ACC_DIR;
            ipgo_pkg::PIN_DATA_IN_OFS: acc = ipgo_pkg::IPGO_ACC_DIN;
            ipgo_pkg::PIN_OUTPUT_DATA_OFS: acc = ipgo_pkg::IPGO_ACC_DOUT;
            ipgo_pkg::PIN_OUTPUT_SET_OFS: acc = ipgo_pkg::IPGO_ACC_SET;
            ipgo_pkg::PIN_OUTPUT_CLR_OFS: acc = ipgo_pkg::IPGO_ACC_CLR;
            default: acc = ipgo_pkg::IPGO_ACC_NONE;
        endcase
    end

    // ************************************************************
    // register file
    // ************************************************************
    // only the two low bits are kept, so bits 31-2 can never be stored
    assign wbits = pwdata_i[1:0];
    // answer in the setup cycle's following edge: one wait-free access phase
    assign setup = psel_i && !penable_i;

    always_comb begin
        state_d = state_q;
        state_d.ready = 1'b0;
        state_d.slverr = 1'b0;
        if (setup) begin
            state_d.ready = 1'b1;
            state_d.rdata = 32'h0000_0000;
            if (!pwrite_i) begin
                unique case (acc)
                    ipgo_pkg::IPGO_ACC_FUNC: begin
                        state_d.rdata[ipgo_pkg::FUNC_BIT] = state_q.gpio_function_select;
                    end
                    ipgo_pkg::IPGO_ACC_DIR: begin
                        state_d.rdata[1:0] = state_q.direction_bits;
                    end
                    ipgo_pkg::IPGO_ACC_DIN: begin
                        state_d.rdata[1:0] = pins_sync;
                    end
                    ipgo_pkg::IPGO_ACC_DOUT: begin
                        // stored bits, never the pin levels
                        state_d.rdata[1:0] = state_q.pin_output_data;
                    end
                    ipgo_pkg::IPGO_ACC_SET, ipgo_pkg::IPGO_ACC_CLR: begin
                        state_d.rdata = ipgo_pkg::ALIAS_READ_VAL;
                    end
                    ipgo_pkg::IPGO_ACC_NONE: begin
                        state_d.slverr = 1'b1;
                    end
                endcase
            end
        end
        // writes take effect at the access-phase edge
        if (psel_i && penable_i && state_q.ready && pwrite_i) begin
            unique case (acc)
                ipgo_pkg::IPGO_ACC_FUNC: begin
                    // output data untouched by mode changes
                    state_d.gpio_function_select = pwdata_i[ipgo_pkg::FUNC_BIT];
                end
                ipgo_pkg::IPGO_ACC_DIR: begin
                    state_d.direction_bits = wbits;
                end
                ipgo_pkg::IPGO_ACC_DIN: begin
                    state_d.direction_bits = state_q.direction_bits;
                end
                ipgo_pkg::IPGO_ACC_DOUT: begin
                    state_d.pin_output_data = wbits;
                end
                ipgo_pkg::IPGO_ACC_SET: begin
                    // bit 1 data, bit 0 clock; zeros leave bits alone
                    state_d.pin_output_data = state_q.pin_output_data | wbits;
                end
                ipgo_pkg::IPGO_ACC_CLR: begin
                    state_d.pin_output_data = state_q.pin_output_data & ~wbits;
                end
                ipgo_pkg::IPGO_ACC_NONE: begin
                    state_d.pin_output_data = state_q.pin_output_data;
                end
            endcase
        end
        // unmapped write flagged in the setup cycle so it lands with pready
        if (setup && pwrite_i && acc == ipgo_pkg::IPGO_ACC_NONE) begin
            state_d.slverr = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= '{
                pin_output_data: ipgo_pkg::OUTPUT_DATA_RST,
                direction_bits: ipgo_pkg::DIRECTION_RST,
                gpio_function_select: ipgo_pkg::FUNCTION_RST,
                rdata: 32'h0000_0000,
                ready: 1'b0,
                slverr: 1'b0
            };
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // pin drivers
    // ************************************************************
    // one cycle later than the register, so each output stays a flop
    ipgo_pin_drv #(
        .OPEN_DRAIN(DATA_OPEN_DRAIN)
    ) u_data_drv (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .gpio_mode_i(state_q.gpio_function_select),
        .dir_out_i(state_q.direction_bits[ipgo_pkg::DATA_BIT]),
        .data_bit_i(state_q.pin_output_data[ipgo_pkg::DATA_BIT]),
        .pin_o(serial_data_pin_o),
        .pin_oe_o(serial_data_pin_oe_o)
    );

    ipgo_pin_drv #(
        .OPEN_DRAIN(CLOCK_OPEN_DRAIN)
    ) u_clock_drv (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .gpio_mode_i(state_q.gpio_function_select),
        .dir_out_i(state_q.direction_bits[ipgo_pkg::CLOCK_BIT]),
        .data_bit_i(state_q.pin_output_data[ipgo_pkg::CLOCK_BIT]),
        .pin_o(serial_clock_pin_o),
        .pin_oe_o(serial_clock_pin_oe_o)
    );

    assign prdata_o = state_q.rdata;
    assign pready_o = state_q.ready;
    assign pslverr_o = state_q.slverr;
    assign gpio_function_select_o = state_q.gpio_function_select;
endmodule

// ---- ipgo_gpio_monitor.sv ----
// checker: bus timing, output-data shadow and pin drive relations
`timescale 1ns/1ns
module ipgo_gpio_monitor #(
    parameter bit DATA_OD = 1'b0,
    parameter bit CLOCK_OD = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic serial_data_pin_i,
    input wire logic serial_data_pin_o,
    input wire logic serial_data_pin_oe_o,
    input wire logic serial_clock_pin_i,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe_o,
    input wire logic gpio_function_select_o
);
    // ****************
    // shadow registers
    // ****************
    logic [1:0] dout_q;
    logic [1:0] dir_q;
    logic fn_q;
    wire wr_w = psel_i && penable_i && pwrite_i && pready_o;
    // an open-drain pin is only driven while its bit asks for low
    wire den_w = fn_q & dir_q[1] & !(DATA_OD & dout_q[1]);
    wire cen_w = fn_q & dir_q[0] & !(CLOCK_OD & dout_q[0]);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dout_q <= 2'h0;
            dir_q <= 2'h0;
            fn_q <= 1'b0;
        end else if (wr_w) begin
            case (paddr_i)
                ipgo_pkg::PIN_FUNCTION_OFS: fn_q <= pwdata_i[0];
                ipgo_pkg::PIN_DIRECTION_OFS: dir_q <= pwdata_i[1:0];
                ipgo_pkg::PIN_OUTPUT_DATA_OFS: dout_q <= pwdata_i[1:0];
                ipgo_pkg::PIN_OUTPUT_SET_OFS: dout_q <= dout_q | pwdata_i[1:0];
                ipgo_pkg::PIN_OUTPUT_CLR_OFS: dout_q <= dout_q & ~pwdata_i[1:0];
                default: ;
            endcase
        end
    end
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    chk_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_upper_read_zero: assert property (pready_o && !pwrite_i |-> prdata_o[31:2] == 30'h0)
        else $error("upper read bits not zero");
    chk_dout_readback: assert property (
        pready_o && !pwrite_i && paddr_i == ipgo_pkg::PIN_OUTPUT_DATA_OFS |-> prdata_o[1:0] == dout_q)
        else $error("output data read mismatch");
    chk_data_enable: assert property (serial_data_pin_oe_o == $past(den_w))
        else $error("data pin enable wrong");
    chk_clock_enable: assert property (serial_clock_pin_oe_o == $past(cen_w))
        else $error("clock pin enable wrong");
    chk_data_level: assert property (serial_data_pin_oe_o |-> serial_data_pin_o == $past(dout_q[1]))
        else $error("data pin level wrong");
    chk_clock_level: assert property (serial_clock_pin_oe_o |-> serial_clock_pin_o == $past(dout_q[0]))
        else $error("clock pin level wrong");
    cover property (wr_w && paddr_i == ipgo_pkg::PIN_OUTPUT_SET_OFS);
    cover property (wr_w && paddr_i == ipgo_pkg::PIN_OUTPUT_CLR_OFS);
    cover property (serial_data_pin_oe_o && serial_clock_pin_oe_o);
endmodule

bind ipgo_gpio ipgo_gpio_monitor #(.DATA_OD(DATA_OPEN_DRAIN), .CLOCK_OD(CLOCK_OPEN_DRAIN)) u_mon (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .serial_data_pin_i(serial_data_pin_i),
    .serial_data_pin_o(serial_data_pin_o), .serial_data_pin_oe_o(serial_data_pin_oe_o),
    .serial_clock_pin_i(serial_clock_pin_i), .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe_o(serial_clock_pin_oe_o), .gpio_function_select_o(gpio_function_select_o));

// ---- ipgo_pin_drv.sv ----
// per-pin output driver: registered level and output enable
`timescale 1ns/1ns
module ipgo_pin_drv #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic gpio_mode_i,
    input wire logic dir_out_i,
    input wire logic data_bit_i,
    output logic pin_o,
    output logic pin_oe_o
);
    typedef struct packed {
        logic level;
        logic enable;
    } ipgo_drv_t;
    ipgo_drv_t state_q;
    ipgo_drv_t state_d;
    logic drive_en;

    // ************************************************************
    // drive decision
    // ************************************************************
    always_comb begin
        drive_en = gpio_mode_i && dir_out_i;
        state_d.level = data_bit_i;
        if (OPEN_DRAIN) begin
            // a one only releases the pin; the pull-up makes the high
            state_d.enable = drive_en && !data_bit_i;
            state_d.level = 1'b0;
        end else begin
            state_d.enable = drive_en;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= '{level: 1'b0, enable: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    assign pin_o = state_q.level;
    assign pin_oe_o = state_q.enable;
endmodule

// ---- ipgo_pkg.sv ----
// package: register map, field positions and reset values of the pin output-data block
package ipgo_pkg;
    // register byte offsets
    localparam logic [7:0] PIN_FUNCTION_OFS = 8'h00;
    localparam logic [7:0] PIN_DIRECTION_OFS = 8'h04;
    localparam logic [7:0] PIN_DATA_IN_OFS = 8'h08;
    localparam logic [7:0] PIN_OUTPUT_DATA_OFS = 8'h0c;
    localparam logic [7:0] PIN_OUTPUT_SET_OFS = 8'h10;
    localparam logic [7:0] PIN_OUTPUT_CLR_OFS = 8'h14;
    // field positions
    localparam int CLOCK_BIT = 0;
    localparam int DATA_BIT = 1;
    localparam int FUNC_BIT = 0;
    localparam int NUM_PINS = 2;
    // reset values
    localparam logic [1:0] OUTPUT_DATA_RST = 2'h0;
    localparam logic [1:0] DIRECTION_RST = 2'h0;
    localparam logic FUNCTION_RST = 1'b0;
    // value returned by reads of the write-only aliases
    localparam logic [31:0] ALIAS_READ_VAL = 32'h0000_0000;
    // access decode result
    typedef enum logic [6:0] {
        IPGO_ACC_NONE = 7'h01,
        IPGO_ACC_FUNC = 7'h02,
        IPGO_ACC_DIR = 7'h04,
        IPGO_ACC_DIN = 7'h08,
        IPGO_ACC_DOUT = 7'h10,
        IPGO_ACC_SET = 7'h20,
        IPGO_ACC_CLR = 7'h40
    } ipgo_acc_t;
endpackage

// ---- ipgo_sync.sv ----
// two-flop synchroniser for the pin input levels
`timescale 1ns/1ns
module ipgo_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ipgo_sync_t;
    ipgo_sync_t state_q;
    ipgo_sync_t state_d;

    // an empty synchroniser has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("synchroniser width must be at least one");
    end

    // ************************************************************
    // first stage feeds only the second
    // ************************************************************
    always_comb begin
        state_d.meta = async_i;
        state_d.stable = state_q.meta;
    end

    // open-drain bus idles high, so the synchroniser resets high
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= '{meta: '1, stable: '1};
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.stable;
endmodule

// ---- tb_top.sv ----
// testbench: apb register sequences and pin drive checks
`timescale 1ns/1ns
module tb_top;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic sdi = 1'b1;
    logic sci = 1'b1;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, sdo, sdoe, sco, scoe;
    logic odo, odoe, oco, ocoe, fsel;
    logic [31:0] r;
    logic e;
    int num_errors = 0;
    int n_tests = 0;
    always #5 clk_i = ~clk_i;
    ipgo_gpio u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .serial_data_pin_i(sdi), .serial_data_pin_o(sdo),
        .serial_data_pin_oe_o(sdoe), .serial_clock_pin_i(sci), .serial_clock_pin_o(sco),
        .serial_clock_pin_oe_o(scoe), .gpio_function_select_o(fsel));
    // open-drain twin on the same bus: its registers track u_dut exactly
    ipgo_gpio #(.DATA_OPEN_DRAIN(1'b1), .CLOCK_OPEN_DRAIN(1'b1)) u_dut_od (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(), .pready_o(), .pslverr_o(), .serial_data_pin_i(sdi), .serial_data_pin_o(odo),
        .serial_data_pin_oe_o(odoe), .serial_clock_pin_i(sci), .serial_clock_pin_o(oco),
        .serial_clock_pin_oe_o(ocoe), .gpio_function_select_o());
    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask
    // waits on pready, never a fixed count: latency belongs to the slave
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 50);
        if (n >= 50) chk(1, 0);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask
    task automatic pins(input logic [3:0] x, input logic [1:0] od);
        repeat (2) @(posedge clk_i);
        #1;
        // a released pin's level means nothing, so only u_dut's driven levels count; the twin's levels are always checked low
        chk({28'h0, sdoe, scoe, sdo & sdoe, sco & scoe}, {28'h0, x});
        chk({28'h0, odoe, ocoe, odo, oco}, {28'h0, od, 2'b00});
    endtask
    task automatic complete_run;
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
    // ****************
    // sequence
    // ****************
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rdchk(ipgo_pkg::PIN_OUTPUT_DATA_OFS, 32'h0);
        apb(1'b1, ipgo_pkg::PIN_OUTPUT_DATA_OFS, 32'hffff_fffe);
        rdchk(ipgo_pkg::PIN_OUTPUT_DATA_OFS, 32'h2);
        apb(1'b1, ipgo_pkg::PIN_OUTPUT_SET_OFS, 32'hffff_fffd);
        rdchk(ipgo_pkg::PIN_OUTPUT_DATA_OFS, 32'h3);
        apb(1'b1, ipgo_pkg::PIN_OUTPUT_CLR_OFS, 32'h2);
        rdchk(ipgo_pkg::PIN_OUTPUT_DATA_OFS, 32'h1);
        apb(1'b1, ipgo_pkg::PIN_OUTPUT_SET_OFS, 32'h2);
        rdchk(ipgo_pkg::PIN_OUTPUT_DATA_OFS, 32'h3);
        apb(1'b1, ipgo_pkg::PIN_DIRECTION_OFS, 32'h3);
        pins(4'h0, 2'h0);
        chk({31'h0, fsel}, 32'h0);
        apb(1'b1, ipgo_pkg::PIN_FUNCTION_OFS, 32'h1);
        rdchk(ipgo_pkg::PIN_OUTPUT_DATA_OFS, 32'h3);
        chk({31'h0, fsel}, 32'h1);
        // the alias read value is not defined; it must not disturb the bits
        apb(1'b0, ipgo_pkg::PIN_OUTPUT_SET_OFS, 32'h0);
        rdchk(ipgo_pkg::PIN_OUTPUT_DATA_OFS, 32'h3);
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, ipgo_pkg::PIN_OUTPUT_DATA_OFS, v);
            pins({2'b11, v[1:0]}, ~v[1:0]);
        end
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, ipgo_pkg::PIN_DIRECTION_OFS, v);
            pins({v[1:0], v[1:0]}, 2'b00);
        end
        sdi <= 1'b0;
        sci <= 1'b1;
        apb(1'b1, ipgo_pkg::PIN_OUTPUT_DATA_OFS, 32'h2);
        rdchk(ipgo_pkg::PIN_OUTPUT_DATA_OFS, 32'h2);
        rdchk(ipgo_pkg::PIN_DATA_IN_OFS, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1);
        complete_run();
    end
endmodule
